// *** dv/asc_smp_src.sv ***
module asc_smp_src
   import asc_pkg::*;
(
   input  wire logic              pclk,
   output logic [2:0]             smp_strobe,
   output asc_pkg::asc_smp_t [2:0] smp_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // sensing front end, one-cycle strobes
   initial begin
      smp_strobe = 3'h0;
      smp_data   = '0;
   end

   task automatic send(input logic [2:0] m, input asc_smp_t x, input asc_smp_t y,
                       input asc_smp_t z);
      smp_strobe <= m;
      smp_data   <= {z, y, x};
      @(posedge pclk);
      smp_strobe <= 3'h0;
      smp_data   <= ~{z, y, x};
   endtask
endmodule

// *** dv/asc_top_chk.sv ***
module asc_top_chk
   import asc_pkg::*;
(
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [7:0]              paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic [2:0]              smp_strobe,
   input wire asc_pkg::asc_smp_t [2:0] smp_data,
   input wire logic                    motion_int,
   input wire logic                    irq
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // read setup decode
   logic rd_s;
   logic ext_ok;
   assign rd_s   = psel && !penable && !pwrite;
   assign ext_ok = prdata[31:8] == 24'h0 && prdata[7:6] == {2{prdata[5]}};

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ==========================================================
   // assertions
   a_x_sign_ext : assert property (rd_s && paddr == 8'hA4 |=> ext_ok)
      else $error("x read not sign extended");
   a_y_sign_ext : assert property (rd_s && paddr == 8'hAC |=> ext_ok)
      else $error("y read not sign extended");
   a_z_sign_ext : assert property (rd_s && paddr == 8'hB4 |=> ext_ok)
      else $error("z read not sign extended");
   a_x_sample_value : assert property (smp_strobe[0] ##1 (rd_s && paddr == 8'hA4)
      |=> prdata[5:0] == $past(smp_data[0], 2)) else $error("x read lost sample");
   a_x_new_flag : assert property (smp_strobe[0] ##1 (rd_s && paddr == 8'h9C)
      |=> prdata[0]) else $error("x new flag missing");
   a_all_new_flag : assert property (smp_strobe == 3'h7 ##1 (rd_s && paddr == 8'h9C)
      |=> prdata[3]) else $error("combined new flag missing");
   a_read_clears_flags : assert property ((rd_s && paddr == 8'hA4 && !smp_strobe[0])
      ##1 (!smp_strobe[0])[*3] ##0 (rd_s && paddr == 8'h9C)
      |=> !prdata[0] && !prdata[4]) else $error("x flags not cleared by read");
   a_reset_quiet : assert property ($rose(presetn) |-> !motion_int [*3])
      else $error("motion interrupt after reset");
   a_ovr_implies_new : assert property (rd_s && paddr == 8'h9C |=> !prdata[7] || prdata[3])
      else $error("combined overrun without combined new");
   a_axis_ovr_flags : assert property ((smp_strobe == 3'h7) ##1 !rd_s ##1
      (smp_strobe == 3'h7 && !rd_s) ##1 (rd_s && paddr == 8'h9C)
      |=> prdata[6:4] == 3'h7) else $error("axis overrun flags missing");
endmodule

bind asc_top asc_top_chk u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .smp_strobe(smp_strobe), .smp_data(smp_data), .motion_int(motion_int), .irq(irq)
);

// *** dv/asc_top_tb_top.sv ***
module asc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import asc_pkg::*;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [7:0]        paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [2:0]        smp_strobe;
   asc_smp_t [2:0]    smp_data;
   logic              motion_int;
   logic              irq;
   logic [31:0]       rd;
   logic              err;
   int                errors = 0;
   int                checked = 0;
   int                cyc = 0;
   logic [7:0]        t_cfg [7] = '{8'h02, 8'h01, 8'h00, 8'h8A, 8'h8A, 8'h02, 8'hC2};
   logic [17:0]       t_smp [7] = '{18'h0000A, 18'h00036, 18'h0000A, 18'h0004A,
                                    18'h0028A, 18'h00004, 18'h0000A};
   logic [6:0]        t_exp = 7'b1010011;

   asc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .smp_strobe(smp_strobe), .smp_data(smp_data),
      .motion_int(motion_int), .irq(irq));
   asc_smp_src src (.pclk(pclk), .smp_strobe(smp_strobe), .smp_data(smp_data));

   initial begin
      forever #5 pclk = ~pclk;
   end

   // ==========================================================
   // reporting and bus tasks
   task automatic give_verdict();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'h0};
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 8'h00);
      chk(rd, exp);
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         give_verdict();
      end
   end

   // ==========================================================
   // test sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rdc(6'h27, 32'h00);
      rdc(6'h30, 32'h00);
      rdc(6'h32, 32'h00);
      src.send(3'h7, 6'h05, 6'h3D, 6'h1F);
      rdc(6'h27, 32'h0F);
      rdc(6'h29, 32'h05);
      rdc(6'h27, 32'h0E);
      rdc(6'h2B, 32'hFD);
      rdc(6'h2D, 32'h1F);
      rdc(6'h27, 32'h00);
      src.send(3'h7, 6'h01, 6'h02, 6'h03);
      @(posedge pclk);
      src.send(3'h7, 6'h21, 6'h02, 6'h03);
      rdc(6'h27, 32'hFF);
      rdc(6'h29, 32'hE1);
      rdc(6'h2B, 32'h02);
      rdc(6'h2D, 32'h03);
      xfer(1'b1, 6'h27, 8'hFF);
      rdc(6'h27, 32'h00);
      xfer(1'b0, 6'h3F, 8'h00);
      chk({31'h0, err}, 32'h1);
      xfer(1'b1, 6'h32, 8'h04);
      rdc(6'h32, 32'h04);
      for (int i = 0; i < 7; i++) begin
         xfer(1'b1, 6'h30, t_cfg[i]);
         src.send(3'h7, t_smp[i][5:0], t_smp[i][11:6], t_smp[i][17:12]);
         repeat (3) @(posedge pclk);
         chk({31'h0, motion_int}, {31'h0, t_exp[i]});
      end
      src.send(3'h1, 6'h0A, 6'h00, 6'h00);
      rdc(6'h29, 32'h0A);
      xfer(1'b1, 6'h38, 8'h01);
      xfer(1'b1, 6'h30, 8'h42);
      src.send(3'h7, 6'h00, 6'h00, 6'h00);
      repeat (3) @(posedge pclk);
      xfer(1'b0, 6'h31, 8'h00);
      src.send(3'h7, 6'h0A, 6'h00, 6'h00);
      repeat (3) @(posedge pclk);
      src.send(3'h7, 6'h00, 6'h00, 6'h00);
      repeat (3) @(posedge pclk);
      chk({31'h0, motion_int}, 32'h1);
      xfer(1'b0, 6'h31, 8'h00);
      chk({31'h0, rd[6]}, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, motion_int}, 32'h0);
      rdc(6'h39, 32'h07);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b1, 6'h3A, 8'h04);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      xfer(1'b1, 6'h39, 8'h07);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      give_verdict();
   end
endmodule

// *** src/asc_defs.svh ***
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
// Overview of operation
// - combined overrun when unread set replaced
// - per-axis overrun on unread sample overwritten
// - combined new-data once all three fresh
// - per-axis new-data flags, zero after reset
// - x sample, 6-bit signed, index 29
// - y sample, 6-bit signed, index 2B
// - z sample, 6-bit signed, index 2D
// - above-threshold enables request event one
// - below-threshold enables request event one
// - or mode: any enabled event fires
// - and mode: all enabled events together
// - six-direction movement recognition mode
// - six-direction position recognition mode
// - setup register resets to zero
// - source read clears active bit and output, unless a latched event fires in the same cycle
// - 7-bit threshold, reset zero
// - latch option holds request until read

// ==========================================================
// register indices, byte address is four times the index
`define ASC_IDX_STATUS   6'h27
`define ASC_IDX_XOUT     6'h29
`define ASC_IDX_YOUT     6'h2B
`define ASC_IDX_ZOUT     6'h2D
`define ASC_IDX_CFG      6'h30
`define ASC_IDX_SRC      6'h31
`define ASC_IDX_THS      6'h32
`define ASC_IDX_CTRL     6'h38
`define ASC_IDX_IRQ_STAT 6'h39
`define ASC_IDX_IRQ_MASK 6'h3A

// ==========================================================
// field positions
`define ASC_STS_ALL_NEW  3
`define ASC_STS_OVR_LSB  4
`define ASC_STS_ALL_OVR  7
`define ASC_CFG_AND      7
`define ASC_CFG_SIXDIR   6
`define ASC_SRC_ACTIVE   6
`define ASC_CTRL_LATCH   0
`define ASC_IRQ_SET      0
`define ASC_IRQ_OVR      1
`define ASC_IRQ_MOTION   2

// ==========================================================
// reset values
`define ASC_CFG_RST      8'h00
`define ASC_THS_RST      7'h00
`define ASC_MASK_RST     3'h0
`define ASC_STAT_RST     3'h0
`endif

// *** src/asc_evt_gen.sv ***
`include "asc_defs.svh"
module asc_evt_gen (
   input wire logic    pclk,
   input wire logic    presetn,
   asc_evt_if.gen      ev
);
   import asc_pkg::*;

   logic [5:0]  hit;
   logic [5:0]  dir;
   logic [5:0]  prev_dir;
   logic        fire;
   logic        event_active;
   logic [5:0]  flags;
   asc_mode_e   mode;

   // ==========================================================
   // per-axis threshold compare, magnitude symmetric
   genvar a;
   generate
      for (a = 0; a < 3; a++) begin : g_cmp
         logic signed [7:0] s;
         logic signed [7:0] t;
         assign s = {{2{ev.smp[a][5]}}, ev.smp[a]};
         assign t = {1'b0, ev.ths};
         assign hit[2*a+1] = s > t;
         assign hit[2*a]   = s < -t;
      end
   endgenerate

   assign dir  = hit & ev.cfg[5:0];
   assign mode = asc_mode_e'({ev.cfg[`ASC_CFG_AND], ev.cfg[`ASC_CFG_SIXDIR]});

   // ==========================================================
   // mode combination
   always_comb begin
      case (mode)
         ASC_MODE_OR:   fire = |dir;
         ASC_MODE_AND:  fire = (ev.cfg[5:0] != 6'h00) &&
                               (dir == ev.cfg[5:0]);
         ASC_MODE_MOVE: fire = (dir != 6'h00) && (dir != prev_dir);
         ASC_MODE_POS:  fire = (dir != 6'h00) && (dir == prev_dir);
         default:       fire = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_dir <= 6'h00;
      end else begin
         prev_dir <= dir;
      end
   end

   // ==========================================================
   // source register, live or latched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_active <= 1'b0;
         flags        <= 6'h00;
      end else if (!ev.latch) begin
         event_active <= fire && !ev.src_rd;
         flags        <= dir;
      end else if (fire) begin
         event_active <= 1'b1;
         flags        <= flags | dir;
      end else if (ev.src_rd) begin
         event_active <= 1'b0;
         flags        <= dir;
      end
   end

   assign ev.src    = {event_active, flags};
   assign ev.active = event_active;
endmodule

// *** src/asc_evt_if.sv ***
interface asc_evt_if;
   import asc_pkg::*;
   logic [7:0]          cfg;
   asc_ths_t            ths;
   logic                latch;
   logic [2:0][5:0]     smp;
   logic                src_rd;
   logic [6:0]          src;
   logic                active;

   modport gen  (input cfg, ths, latch, smp, src_rd, output src, active);
   modport host (output cfg, ths, latch, smp, src_rd, input src, active);
endinterface

// *** src/asc_pkg.sv ***
package asc_pkg;
   // interrupt one combination modes, order follows {and, six-dir}
   typedef enum logic [1:0] {
      ASC_MODE_OR,
      ASC_MODE_MOVE,
      ASC_MODE_AND,
      ASC_MODE_POS
   } asc_mode_e;

   typedef logic signed [5:0] asc_smp_t;
   typedef logic [6:0]        asc_ths_t;
endpackage

// *** src/asc_top.sv ***
// Decided for this implementation: register access over APB.
`include "asc_defs.svh"
module asc_top (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [7:0]              paddr,
   input  wire logic [31:0]             pwdata,
   output logic [31:0]                  prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic [2:0]              smp_strobe,
   input  wire asc_pkg::asc_smp_t [2:0] smp_data,
   output logic                         motion_int,
   output logic                         irq
);
   import asc_pkg::*;

   // ==========================================================
   // bus decode
   logic [5:0]  idx;
   logic        setup_rd;
   logic        acc_wr;
   logic        acc;
   logic        mapped;
   logic [7:0]  rd_mux;

   assign idx      = paddr[7:2];
   assign setup_rd = psel && !penable && !pwrite;
   assign acc      = psel && penable;
   assign acc_wr   = acc && pwrite && mapped;

   // ==========================================================
   // register state
   logic [7:0]       cfg;
   asc_ths_t         ths;
   logic             latch;
   logic [2:0]       irq_stat;
   logic [2:0]       irq_mask;
   logic [2:0][5:0]  smp_q;
   logic [2:0]       new_q;
   logic [2:0]       ovr_q;
   logic [2:0]       rd_axis;
   logic [2:0]       rd_seen;
   logic             all_new;
   logic             all_ovr;
   logic             set_done;
   logic             set_ovr;
   logic             seen_all;
   logic             src_rd;
   logic             motion_q;
   logic [2:0]       irq_ev;

   asc_evt_if evb ();

   // ==========================================================
   // address map
   always_comb begin
      mapped = 1'b1;
      rd_mux = 8'h00;
      case (idx)
         `ASC_IDX_STATUS: begin
            rd_mux = {all_ovr, ovr_q, all_new, new_q};
         end
         `ASC_IDX_XOUT: begin
            rd_mux = {{2{smp_q[0][5]}}, smp_q[0]};
         end
         `ASC_IDX_YOUT: begin
            rd_mux = {{2{smp_q[1][5]}}, smp_q[1]};
         end
         `ASC_IDX_ZOUT: begin
            rd_mux = {{2{smp_q[2][5]}}, smp_q[2]};
         end
         `ASC_IDX_CFG: begin
            rd_mux = cfg;
         end
         `ASC_IDX_SRC: begin
            rd_mux = {1'b0, evb.src};
         end
         `ASC_IDX_THS: begin
            rd_mux = {1'b0, ths};
         end
         `ASC_IDX_CTRL: begin
            rd_mux = {7'h00, latch};
         end
         `ASC_IDX_IRQ_STAT: begin
            rd_mux = {5'h00, irq_stat};
         end
         `ASC_IDX_IRQ_MASK: begin
            rd_mux = {5'h00, irq_mask};
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
      if (paddr[1:0] != 2'b00) begin
         mapped = 1'b0;
         rd_mux = 8'h00;
      end
   end

   // ==========================================================
   // apb answer, zero wait states
   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

   // read data caught at the setup edge, together with read side effects
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata <= {24'h00_0000, rd_mux};
      end
   end

   // ==========================================================
   // read side effects
   assign rd_axis[0] = setup_rd && mapped && (idx == `ASC_IDX_XOUT);
   assign rd_axis[1] = setup_rd && mapped && (idx == `ASC_IDX_YOUT);
   assign rd_axis[2] = setup_rd && mapped && (idx == `ASC_IDX_ZOUT);
   assign src_rd     = setup_rd && mapped && (idx == `ASC_IDX_SRC);

   // ==========================================================
   // writable configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= `ASC_CFG_RST;
      end else if (acc_wr && idx == `ASC_IDX_CFG) begin
         cfg <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ths <= `ASC_THS_RST;
      end else if (acc_wr && idx == `ASC_IDX_THS) begin
         ths <= pwdata[6:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch <= 1'b0;
      end else if (acc_wr && idx == `ASC_IDX_CTRL) begin
         latch <= pwdata[`ASC_CTRL_LATCH];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= `ASC_MASK_RST;
      end else if (acc_wr && idx == `ASC_IDX_IRQ_MASK) begin
         irq_mask <= pwdata[2:0];
      end
   end

   // ==========================================================
   // per-axis sample, new-data and overrun
   genvar a;
   generate
      for (a = 0; a < 3; a++) begin : g_axis
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               smp_q[a] <= 6'h00;
            end else if (smp_strobe[a]) begin
               smp_q[a] <= smp_data[a];
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               new_q[a] <= 1'b0;
            end else if (smp_strobe[a]) begin
               new_q[a] <= 1'b1;
            end else if (rd_axis[a]) begin
               new_q[a] <= 1'b0;
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ovr_q[a] <= 1'b0;
            end else if (smp_strobe[a] && new_q[a] && !rd_axis[a]) begin
               ovr_q[a] <= 1'b1;
            end else if (rd_axis[a]) begin
               ovr_q[a] <= 1'b0;
            end
         end
      end
   endgenerate

   // ==========================================================
   // combined flags
   // a set completes when the last missing axis arrives
   assign set_done = (|smp_strobe) && (&(new_q | smp_strobe)) && !(&new_q);
   assign set_ovr  = (&smp_strobe) && all_new && !(|rd_seen) &&
                     !(|rd_axis);
   assign seen_all = &(rd_seen | rd_axis);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_seen <= 3'h0;
      end else if (seen_all) begin
         rd_seen <= 3'h0;
      end else begin
         rd_seen <= rd_seen | rd_axis;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         all_new <= 1'b0;
      end else if (set_done || set_ovr) begin
         all_new <= 1'b1;
      end else if (seen_all) begin
         all_new <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         all_ovr <= 1'b0;
      end else if (set_ovr) begin
         all_ovr <= 1'b1;
      end else if (seen_all) begin
         all_ovr <= 1'b0;
      end
   end

   // ==========================================================
   // interrupt one generator
   assign evb.cfg    = cfg;
   assign evb.ths    = ths;
   assign evb.latch  = latch;
   assign evb.smp    = smp_q;
   assign evb.src_rd = src_rd;

   asc_evt_gen u_evt (
      .pclk    (pclk),
      .presetn (presetn),
      .ev      (evb.gen)
   );

   assign motion_int = evb.active;

   // ==========================================================
   // block interrupt: sticky status, write one to clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motion_q <= 1'b0;
      end else begin
         motion_q <= evb.active;
      end
   end

   assign irq_ev[`ASC_IRQ_SET]    = set_done || set_ovr;
   assign irq_ev[`ASC_IRQ_OVR]    = set_ovr || |(smp_strobe & new_q & ~rd_axis);
   assign irq_ev[`ASC_IRQ_MOTION] = evb.active && !motion_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= `ASC_STAT_RST;
      end else if (acc_wr && idx == `ASC_IDX_IRQ_STAT) begin
         irq_stat <= (irq_stat & ~pwdata[2:0]) | irq_ev;
      end else begin
         irq_stat <= irq_stat | irq_ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_mask);
      end
   end
endmodule
